//--- ahs_top.sv
// Alarm history, active alarm, fault reporting and stop select, as an APB slave.
// Assumes alarm events and speed status come synchronous to pclk from the drive core;
// the point-table and parameter-fault sources come from pins and are synchronised here.
// Function
// - History record sub-index zero reads seven
// - Sub one packs alarm and detail number
// - Secondary alarm sub-entry reads constant zero
// - Seconds stamp since 1970 epoch, 32 bits
// - Fraction, zone, daylight stamps, 32 bits each
// - Key 1EA5h write clears whole history
// - Wide current alarm object, 32 bits
// - Narrow current alarm object, 16 bits
// - Point-table fault: two subs, number, element
// - Count of parameters in error
// - Up to 254 faulty parameters, in order
// - Key 1EA5h write resets active alarm
// - Alarm number selects one of three methods
// - Forced stop decelerates, then brakes
// - Dynamic brake directly; coast without brake
// - Electronic brake only for qualifying motors
// - No forced decel in torque modes
// - Cyclic sync ignores commands while alarm-stopped
// - Select field 2 enables decel, 0 disables
// - Decel: internal speed command, outputs on
// - Brake path: outputs off, dynamic or electronic brake, or coast
// - History keeps sixteen newest alarms with time
// - Ramp down, below zero speed cut output
`timescale 1ns/10ps
module ahs_top
	import ahs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        alarm_event,
	input  wire logic [15:0] alarm_code,
	input  wire logic [15:0] alarm_detail,
	input  wire ahs_method_t alarm_method,
	input  wire logic [31:0] hour_stamp,
	input  wire logic [31:0] sec_stamp,
	input  wire logic [31:0] frac_stamp,
	input  wire logic [31:0] zone_stamp,
	input  wire logic [31:0] dst_stamp,
	input  wire logic        speed_low,
	input  wire logic        cmd_valid,
	input  wire logic        pt_fault_pin,
	input  wire logic [15:0] pt_num_pin,
	input  wire logic [15:0] pt_elem_pin,
	input  wire logic        pf_push_pin,
	input  wire logic [15:0] pf_param_pin,
	output logic             brake_interlock_out,
	output logic             brake_interlock_out_alt,
	output logic             alarm_out,
	output logic             decel_cmd_out,
	output logic             base_off_out,
	output ahs_action_t      brake_action_out,
	output logic             cmd_accept_out,
	output logic             parameter_fault_alarm
);

	// Word-wide record store, newest at index 0
	logic [31:0] h_num_q   [AHS_HIST_DEPTH];  // Alarm and detail
	logic [31:0] h_hour_q  [AHS_HIST_DEPTH];  // Power-on hours
	logic [31:0] h_sec_q   [AHS_HIST_DEPTH];  // Epoch seconds
	logic [31:0] h_frac_q  [AHS_HIST_DEPTH];  // Sub-second digits
	logic [31:0] h_zone_q  [AHS_HIST_DEPTH];  // Time zone
	logic [31:0] h_dst_q   [AHS_HIST_DEPTH];  // Daylight state
	logic [15:0] pf_list_q [AHS_PF_DEPTH];    // Faulty parameter numbers

	logic [15:0] cur_alarm_q;   // Active alarm number
	logic [15:0] pt_num_q;      // Failing point table
	logic [15:0] pt_elem_q;     // Failing element
	logic [15:0] pf_count_q;    // Parameters in error
	logic [8:0]  ctrl_q;        // Control register
	logic [7:0]  sub_sel_q;     // Sub-index for record and array reads
	logic [31:0] prdata_q;      // Registered read data
	logic        pready_q;      // Access-phase ready
	logic        pslverr_q;     // Error answer
	logic [7:0]  outs_q;        // Registered pin outputs
	logic [1:0]  brk_q;         // Registered brake action
	logic        cmd_acc_q;     // Registered command accept

	// Pin synchronisers: stage one feeds stage two only
	logic [32:0] pt_s1_q;
	logic [32:0] pt_s2_q;
	logic [16:0] pf_s1_q;
	logic [16:0] pf_s2_q;
	logic        pf_prev_q;     // Edge detector on stage two

	// Bus decode wires
	logic [15:0] idx;
	logic        access;
	logic        wr_acc;
	logic        rd_acc;
	logic        is_hist;
	logic [3:0]  hist_n;
	logic        mapped;
	logic        ro_hit;
	logic        wo_hit;
	logic        bad;
	logic        key_ok;
	logic        clr_hist;
	logic        rst_alarm;
	logic [31:0] rd_word;
	logic [31:0] hist_word;
	logic [31:0] pf_word;
	logic        pf_push;
	logic        alarm_now;

	// Stop sequencer results
	logic        seq_decel;
	logic        seq_base_off;
	ahs_action_t seq_action;
	logic        seq_stopped;

	// Index equals address over four
	assign idx    = paddr[17:2];
	assign access = psel && penable && !pready_q;
	assign wr_acc = access && pwrite;
	assign rd_acc = access && !pwrite;

	// History block spans sixteen consecutive indexes
	assign is_hist = (idx[15:4] == AHS_IDX_HIST0[15:4]);
	assign hist_n  = idx[3:0];

	// Read-only and write-only objects refuse the other direction
	assign ro_hit = is_hist || idx == AHS_IDX_ALM_WIDE || idx == AHS_IDX_ALM_NAR
		|| idx == AHS_IDX_PT_FAULT || idx == AHS_IDX_PF_COUNT || idx == AHS_IDX_PF_LIST
		|| idx == AHS_IDX_STATUS;
	assign wo_hit = idx == AHS_IDX_CLR_KEY || idx == AHS_IDX_RST_KEY;
	assign mapped = ro_hit || wo_hit || idx == AHS_IDX_CTRL || idx == AHS_IDX_SUB_SEL;
	assign bad    = !mapped || (pwrite && ro_hit) || (!pwrite && wo_hit);

	// Keyed writes; any other value is silently ignored
	assign key_ok    = (pwdata[15:0] == AHS_KEY);
	assign clr_hist  = wr_acc && idx == AHS_IDX_CLR_KEY && key_ok;
	assign rst_alarm = wr_acc && idx == AHS_IDX_RST_KEY && key_ok;

	// A new alarm is only logged while none is active
	assign alarm_now = alarm_event && !seq_stopped;

	// Record sub-entry mux
	always_comb begin
		case (sub_sel_q)
			8'd0:    hist_word = {24'h00_0000, AHS_HIST_SUBS};
			8'd1:    hist_word = h_num_q[hist_n];
			8'd2:    hist_word = h_hour_q[hist_n];
			8'd3:    hist_word = {16'h0000, AHS_SEC_ALARM};
			8'd4:    hist_word = h_sec_q[hist_n];
			8'd5:    hist_word = h_frac_q[hist_n];
			8'd6:    hist_word = h_zone_q[hist_n];
			8'd7:    hist_word = h_dst_q[hist_n];
			default: hist_word = 32'h0000_0000;
		endcase
	end

	// Parameter list: sub zero is slot count, subs 1..254 are slots
	assign pf_word = (sub_sel_q == 8'd0) ? {24'h00_0000, AHS_PF_SUBS} :
		(sub_sel_q == 8'hff) ? 32'h0000_0000 : {16'h0000, pf_list_q[sub_sel_q - 8'd1]};

	// Read mux by object index
	always_comb begin
		rd_word = 32'h0000_0000;
		if (is_hist) begin
			rd_word = hist_word;
		end else begin
			case (idx)
				AHS_IDX_ALM_WIDE: rd_word = {16'h0000, cur_alarm_q};
				AHS_IDX_ALM_NAR:  rd_word = {16'h0000, cur_alarm_q};
				AHS_IDX_PT_FAULT: begin
					// Sub zero is count, one the table, two the element
					case (sub_sel_q)
						8'd0:    rd_word = {24'h00_0000, AHS_PT_SUBS};
						8'd1:    rd_word = {16'h0000, pt_num_q};
						8'd2:    rd_word = {16'h0000, pt_elem_q};
						default: rd_word = 32'h0000_0000;
					endcase
				end
				AHS_IDX_PF_COUNT: rd_word = {16'h0000, pf_count_q};
				AHS_IDX_PF_LIST:  rd_word = pf_word;
				AHS_IDX_CTRL:     rd_word = {23'h00_0000, ctrl_q};
				AHS_IDX_SUB_SEL:  rd_word = {24'h00_0000, sub_sel_q};
				AHS_IDX_STATUS:   rd_word = {27'h000_0000, seq_action, seq_base_off,
					seq_decel, seq_stopped};
				default:          rd_word = 32'h0000_0000;
			endcase
		end
	end

	// APB answer: one wait state, data and error registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= access;
			pslverr_q <= access && bad;
			prdata_q  <= (rd_acc && !bad) ? rd_word : 32'h0000_0000;
		end
	end

	// Control and sub-index registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= {5'b1_1000, AHS_CTRL_RESET};
			sub_sel_q <= 8'h00;
		end else begin
			if (wr_acc && idx == AHS_IDX_CTRL) begin
				ctrl_q <= pwdata[8:0];
			end
			if (wr_acc && idx == AHS_IDX_SUB_SEL) begin
				sub_sel_q <= pwdata[7:0];
			end
		end
	end

	// History shift on a new alarm; a same-cycle clear empties all but the new record
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < AHS_HIST_DEPTH; i++) begin
				h_num_q[i]  <= 32'h0000_0000;
				h_hour_q[i] <= 32'h0000_0000;
				h_sec_q[i]  <= 32'h0000_0000;
				h_frac_q[i] <= 32'h0000_0000;
				h_zone_q[i] <= 32'h0000_0000;
				h_dst_q[i]  <= 32'h0000_0000;
			end
		end else if (alarm_now) begin
			for (int i = AHS_HIST_DEPTH - 1; i > 0; i--) begin
				h_num_q[i]  <= clr_hist ? 32'h0000_0000 : h_num_q[i-1];
				h_hour_q[i] <= clr_hist ? 32'h0000_0000 : h_hour_q[i-1];
				h_sec_q[i]  <= clr_hist ? 32'h0000_0000 : h_sec_q[i-1];
				h_frac_q[i] <= clr_hist ? 32'h0000_0000 : h_frac_q[i-1];
				h_zone_q[i] <= clr_hist ? 32'h0000_0000 : h_zone_q[i-1];
				h_dst_q[i]  <= clr_hist ? 32'h0000_0000 : h_dst_q[i-1];
			end
			h_num_q[0]  <= {alarm_code, alarm_detail};
			h_hour_q[0] <= hour_stamp;
			h_sec_q[0]  <= sec_stamp;
			h_frac_q[0] <= frac_stamp;
			h_zone_q[0] <= zone_stamp;
			h_dst_q[0]  <= dst_stamp;
		end else if (clr_hist) begin
			for (int i = 0; i < AHS_HIST_DEPTH; i++) begin
				h_num_q[i]  <= 32'h0000_0000;
				h_hour_q[i] <= 32'h0000_0000;
				h_sec_q[i]  <= 32'h0000_0000;
				h_frac_q[i] <= 32'h0000_0000;
				h_zone_q[i] <= 32'h0000_0000;
				h_dst_q[i]  <= 32'h0000_0000;
			end
		end
	end

	// Active alarm: a new alarm set wins over a same-cycle reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_alarm_q <= 16'h0000;
		end else if (alarm_now) begin
			cur_alarm_q <= alarm_code;
		end else if (rst_alarm) begin
			cur_alarm_q <= 16'h0000;
		end
	end

	// Two-flop synchronisers for the fault pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pt_s1_q   <= 33'h0_0000_0000;
			pt_s2_q   <= 33'h0_0000_0000;
			pf_s1_q   <= 17'h0_0000;
			pf_s2_q   <= 17'h0_0000;
			pf_prev_q <= 1'b0;
		end else begin
			pt_s1_q   <= {pt_fault_pin, pt_num_pin, pt_elem_pin};
			pt_s2_q   <= pt_s1_q;
			pf_s1_q   <= {pf_push_pin, pf_param_pin};
			pf_s2_q   <= pf_s1_q;
			pf_prev_q <= pf_s2_q[16];
		end
	end

	// Rising edge of the synchronised push strobe adds one list entry
	assign pf_push = pf_s2_q[16] && !pf_prev_q;

	// Point-table capture while the fault is flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pt_num_q  <= 16'h0000;
			pt_elem_q <= 16'h0000;
		end else if (pt_s2_q[32]) begin
			pt_num_q  <= pt_s2_q[31:16];
			pt_elem_q <= pt_s2_q[15:0];
		end
	end

	// Parameter fault list fills in order; extra entries past 254 are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pf_count_q <= 16'h0000;
		end else if (pf_push && pf_count_q < 16'(AHS_PF_DEPTH)) begin
			pf_count_q <= pf_count_q + 16'h0001;
		end else if (rst_alarm) begin
			pf_count_q <= 16'h0000;
		end
	end

	// List slots hold no reset so the array maps onto memory
	always_ff @(posedge pclk) begin
		if (pf_push && pf_count_q < 16'(AHS_PF_DEPTH)) begin
			pf_list_q[pf_count_q[7:0]] <= pf_s2_q[15:0];
		end
	end

	// Stop method selection and sequencing
	ahs_stop_seq u_seq (
		.pclk              (pclk),
		.presetn           (presetn),
		.alarm_pulse       (alarm_now),
		.alarm_clear       (rst_alarm),
		.method            (alarm_method),
		.stop_decel_select (ctrl_q[AHS_CTRL_SEL_LSB +: 4]),
		.torque_mode       (ctrl_q[AHS_CTRL_TORQUE]),
		.cont_torque_mode  (ctrl_q[AHS_CTRL_CTT]),
		.has_db            (ctrl_q[AHS_CTRL_HAS_DB]),
		.edb_motor         (ctrl_q[AHS_CTRL_EDB_MTR]),
		.speed_low         (speed_low),
		.decel_active      (seq_decel),
		.base_off          (seq_base_off),
		.action            (seq_action),
		.stopped           (seq_stopped)
	);

	// Pin outputs registered; interlock and alarm are high while healthy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outs_q    <= 8'h00;
			brk_q     <= 2'b00;
			cmd_acc_q <= 1'b0;
		end else begin
			outs_q[0] <= !seq_stopped;
			outs_q[1] <= !seq_stopped;
			outs_q[2] <= !seq_stopped;
			outs_q[3] <= seq_decel;
			outs_q[4] <= seq_base_off;
			outs_q[5] <= pf_count_q != 16'h0000;
			outs_q[7:6] <= 2'b00;
			brk_q     <= seq_action;
			// Cyclic synchronous mode drops commands during an alarm stop
			cmd_accept_d_blk: cmd_acc_q <= cmd_valid && !(ctrl_q[AHS_CTRL_CSM] && seq_stopped);
		end
	end

	assign prdata                  = prdata_q;
	assign pready                  = pready_q;
	assign pslverr                 = pslverr_q;
	assign brake_interlock_out     = outs_q[0];
	assign brake_interlock_out_alt = outs_q[1];
	assign alarm_out               = outs_q[2];
	assign decel_cmd_out           = outs_q[3];
	assign base_off_out            = outs_q[4];
	assign parameter_fault_alarm   = outs_q[5];
	assign brake_action_out        = ahs_action_t'(brk_q);
	assign cmd_accept_out          = cmd_acc_q;

endmodule : ahs_top

//--- ahs_pkg.sv
// Package for the alarm history and stop select block: register map, keys, field layouts,
// stop methods and reset values.
// Assumes an APB slave with 32-bit data; printed object indexes are word indexes.
package ahs_pkg;

	// Object indexes; byte address is four times the index
	localparam logic [15:0] AHS_IDX_HIST0     = 16'h2a00;  // Newest record
	localparam logic [15:0] AHS_IDX_HIST15    = 16'h2a0f;  // alarm_history_oldest_record
	localparam logic [15:0] AHS_IDX_CLR_KEY   = 16'h2a40;  // alarm_history_clear_key
	localparam logic [15:0] AHS_IDX_ALM_WIDE  = 16'h2a41;  // active_alarm_wide
	localparam logic [15:0] AHS_IDX_ALM_NAR   = 16'h2a42;  // active_alarm_narrow
	localparam logic [15:0] AHS_IDX_PT_FAULT  = 16'h2a43;  // point_table_fault
	localparam logic [15:0] AHS_IDX_PF_COUNT  = 16'h2a44;  // parameter_fault_count
	localparam logic [15:0] AHS_IDX_PF_LIST   = 16'h2a45;  // parameter_fault_list
	localparam logic [15:0] AHS_IDX_RST_KEY   = 16'h2a46;  // alarm_reset_key
	localparam logic [15:0] AHS_IDX_CTRL      = 16'h2a50;  // Control: stop select, modes
	localparam logic [15:0] AHS_IDX_SUB_SEL   = 16'h2a51;  // Sub-index selector
	localparam logic [15:0] AHS_IDX_STATUS    = 16'h2a52;  // Stop sequence status

	// Keys and constants
	localparam logic [15:0] AHS_KEY           = 16'h1ea5;
	localparam logic [7:0]  AHS_HIST_SUBS     = 8'h07;
	localparam logic [7:0]  AHS_PT_SUBS       = 8'h02;
	localparam logic [7:0]  AHS_PF_SUBS       = 8'hfe;
	localparam logic [15:0] AHS_SEC_ALARM     = 16'h0000;
	localparam int          AHS_HIST_DEPTH    = 16;
	localparam int          AHS_PF_DEPTH      = 254;

	// Stop decel selection field values
	localparam logic [3:0]  AHS_DECEL_OFF     = 4'h0;
	localparam logic [3:0]  AHS_DECEL_ON      = 4'h2;
	localparam logic [3:0]  AHS_CTRL_RESET    = 4'h2;

	// Control register field positions
	localparam int          AHS_CTRL_SEL_LSB  = 0;
	localparam int          AHS_CTRL_TORQUE   = 4;
	localparam int          AHS_CTRL_CTT      = 5;
	localparam int          AHS_CTRL_CSM      = 6;
	localparam int          AHS_CTRL_HAS_DB   = 7;
	localparam int          AHS_CTRL_EDB_MTR  = 8;

	// Per-alarm stop method
	typedef enum logic [1:0] {
		AHS_STOP_DECEL = 2'd0,
		AHS_STOP_DB    = 2'd1,
		AHS_STOP_EDB   = 2'd2
	} ahs_method_t;

	// Applied stop action
	typedef enum logic [1:0] {
		AHS_ACT_NONE  = 2'd0,
		AHS_ACT_DB    = 2'd1,
		AHS_ACT_EDB   = 2'd2,
		AHS_ACT_COAST = 2'd3
	} ahs_action_t;

endpackage : ahs_pkg

//--- ahs_stop_seq.sv
// Stop sequencer: picks and runs the stop method for an alarm.
// Assumes alarm_pulse is a one-cycle pulse on pclk and speed_low is synchronous.
`timescale 1ns/10ps
module ahs_stop_seq
	import ahs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        alarm_pulse,
	input  wire logic        alarm_clear,
	input  wire ahs_method_t method,
	input  wire logic [3:0]  stop_decel_select,
	input  wire logic        torque_mode,
	input  wire logic        cont_torque_mode,
	input  wire logic        has_db,
	input  wire logic        edb_motor,
	input  wire logic        speed_low,
	output logic             decel_active,
	output logic             base_off,
	output ahs_action_t      action,
	output logic             stopped
);

	typedef enum logic [1:0] {SQ_IDLE, SQ_DECEL, SQ_BRAKE} ahs_sq_t;

	ahs_sq_t     state_q;     // Sequencer state
	ahs_sq_t     state_d;     // Next state
	ahs_action_t act_q;       // Latched brake action
	ahs_action_t act_d;       // Next action
	logic        decel_ok;    // Deceleration allowed for this alarm
	ahs_action_t brake_pick;  // Brake to use after any deceleration

	// Decel only for decel-type alarms, enabled, never in torque modes
	assign decel_ok = (method == AHS_STOP_DECEL) && (stop_decel_select == AHS_DECEL_ON)
		&& !torque_mode && !cont_torque_mode;

	// Electronic brake only on qualifying motors; no brake fitted means coast
	assign brake_pick = (method == AHS_STOP_EDB && edb_motor) ? AHS_ACT_EDB :
		(has_db ? AHS_ACT_DB : AHS_ACT_COAST);

	// Next-state decode
	always_comb begin
		state_d = state_q;
		act_d   = act_q;
		case (state_q)
			SQ_IDLE: begin
				if (alarm_pulse) begin
					act_d   = brake_pick;
					state_d = decel_ok ? SQ_DECEL : SQ_BRAKE;
				end
			end
			SQ_DECEL: begin
				// Brake waits until speed is under the zero-speed level
				if (speed_low) begin
					state_d = SQ_BRAKE;
				end
			end
			SQ_BRAKE: begin
				if (alarm_clear) begin
					state_d = SQ_IDLE;
					act_d   = AHS_ACT_NONE;
				end
			end
			default: begin
				state_d = SQ_IDLE;
				act_d   = AHS_ACT_NONE;
			end
		endcase
		// Reset during decel abandons the stop
		if (alarm_clear && state_q == SQ_DECEL) begin
			state_d = SQ_IDLE;
			act_d   = AHS_ACT_NONE;
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SQ_IDLE;
			act_q   <= AHS_ACT_NONE;
		end else begin
			state_q <= state_d;
			act_q   <= act_d;
		end
	end

	// Internal speed command ramps only in decel state
	assign decel_active = (state_q == SQ_DECEL);
	assign base_off     = (state_q == SQ_BRAKE);
	assign action       = (state_q == SQ_BRAKE) ? act_q : AHS_ACT_NONE;
	assign stopped      = (state_q != SQ_IDLE);

endmodule : ahs_stop_seq

//--- ahs_top_monitor.sv
// Concurrent checks on the ports of the alarm history and stop select block.
// Assumes one clock domain, pclk, and the asynchronous active-low presetn.
`timescale 1ns/10ps
module ahs_top_monitor
	import ahs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        alarm_event,
	input  wire ahs_method_t alarm_method,
	input  wire logic        speed_low,
	input  wire logic        brake_interlock_out,
	input  wire logic        brake_interlock_out_alt,
	input  wire logic        alarm_out,
	input  wire logic        decel_cmd_out,
	input  wire logic        base_off_out,
	input  wire ahs_action_t brake_action_out
);
	// All checks share the bus clock; reset silences them
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	read_answer_a: assert property (psel && $rose(penable) |=> pready)
		else $error("Object access not answered one cycle into the access phase");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("Error flag outside the answer cycle");
	// Outputs lag the stop state by one register, hence two cycles from the event
	alarm_drop_a: assert property (alarm_event && alarm_out |-> ##2
		(!alarm_out && !brake_interlock_out && !brake_interlock_out_alt))
		else $error("Interlock and alarm outputs not dropped after an alarm");
	db_direct_a: assert property (alarm_event && alarm_out && alarm_method == AHS_STOP_DB
		|-> ##2 (base_off_out && !decel_cmd_out))
		else $error("Brake stop did not brake at once");
	decel_then_brake_a: assert property (decel_cmd_out && speed_low |-> ##2
		(base_off_out && !decel_cmd_out))
		else $error("Deceleration did not hand over to the brake at zero speed");
	brake_excl_a: assert property (decel_cmd_out |-> !base_off_out)
		else $error("Brake applied during deceleration");
	action_state_a: assert property (base_off_out == (brake_action_out != AHS_ACT_NONE))
		else $error("Brake action and output-off state disagree");

	// Main scenarios reached
	cover property (decel_cmd_out && speed_low);
	cover property (brake_action_out == AHS_ACT_COAST);
	cover property (brake_action_out == AHS_ACT_EDB);
	cover property (pslverr && pready);
endmodule : ahs_top_monitor

bind ahs_top ahs_top_monitor ahs_top_monitor_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.alarm_event(alarm_event), .alarm_method(alarm_method), .speed_low(speed_low),
	.brake_interlock_out(brake_interlock_out), .alarm_out(alarm_out),
	.brake_interlock_out_alt(brake_interlock_out_alt), .decel_cmd_out(decel_cmd_out),
	.base_off_out(base_off_out), .brake_action_out(brake_action_out));

//--- ahs_ctrl_model.sv
// Motion controller model: reads and writes objects as an APB master.
// Assumes the slave raises pready for one cycle; waits are cut by the bench timeout.
`timescale 1ns/10ps
module ahs_ctrl_model (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [17:0]      paddr,
	output logic [31:0]      pwdata
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h0_0000;
		pwdata = 32'h0000_0000;
	end

	// One transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines stop showing the last value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask : xfer
endmodule : ahs_ctrl_model

//--- ahs_top_tb_top.sv
// Self-checking bench: object accesses over APB, alarms and fault pins driven directly.
// Assumes the controller model and the bound monitor are compiled alongside.
`timescale 1ns/10ps
module ahs_top_tb_top;
	import ahs_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, alarm_event = 1'b0, speed_low = 1'b0, cmd_valid = 1'b0;
	logic pt_fault_pin = 1'b0, pf_push_pin = 1'b0;
	logic [15:0] alarm_code = '0, alarm_detail = '0, pt_num_pin = '0, pt_elem_pin = '0;
	logic [15:0] pf_param_pin = '0;
	logic [31:0] hour_stamp = '0, sec_stamp = '0, frac_stamp = '0, zone_stamp = '0;
	logic [31:0] dst_stamp = '0, prdata, pwdata;
	logic psel, penable, pwrite, pready, pslverr, brake_interlock_out, brake_interlock_out_alt;
	logic alarm_out, decel_cmd_out, base_off_out, cmd_accept_out, parameter_fault_alarm;
	logic [17:0] paddr;
	ahs_method_t alarm_method = AHS_STOP_DB;
	ahs_action_t brake_action_out;
	int miscompares = 0, check_count = 0, cyc = 0;
	// Stop table: control word, method, resulting brake action; row 7 decelerates first
	logic [31:0] ctl_tab [8] = '{32'h0000_01c2, 32'h0000_0142, 32'h0000_01c2, 32'h0000_00c2,
		32'h0000_01d2, 32'h0000_01e2, 32'h0000_01c0, 32'h0000_01c2};
	ahs_method_t m_tab [8] = '{AHS_STOP_DB, AHS_STOP_DB, AHS_STOP_EDB, AHS_STOP_EDB,
		AHS_STOP_DECEL, AHS_STOP_DECEL, AHS_STOP_DECEL, AHS_STOP_DECEL};
	ahs_action_t a_tab [8] = '{AHS_ACT_DB, AHS_ACT_COAST, AHS_ACT_EDB, AHS_ACT_DB,
		AHS_ACT_DB, AHS_ACT_DB, AHS_ACT_DB, AHS_ACT_DB};

	always #20 pclk = ~pclk;

	ahs_ctrl_model ahs_ctrl_model_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	ahs_top ahs_top_inst (.*);

	task automatic wrap_up;
		$display("checks %0d, miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Access with expected error flag; reads also compare data
	task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d,
		input logic e);
		logic [31:0] r;
		logic er;
		ahs_ctrl_model_inst.xfer(w, idx, d, r, er);
		chk("pslverr", {31'h0, er}, {31'h0, e});
		if (!w) chk("prdata", r, d);
	endtask : acc

	task automatic sub(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] e);
		acc(1'b1, AHS_IDX_SUB_SEL, {24'h0, s}, 1'b0);
		acc(1'b0, idx, e, 1'b0);
	endtask : sub

	// One alarm pulse with stamps derived from the code
	task automatic fire(input logic [15:0] c, input ahs_method_t m);
		@(posedge pclk);
		{alarm_event, alarm_code, alarm_detail} <= {1'b1, c, ~c};
		alarm_method <= m;
		{hour_stamp, sec_stamp} <= {16'h0, c, c, c};
		{frac_stamp, zone_stamp, dst_stamp} <= {c, 16'h1, c, 16'h2, c, 16'h3};
		@(posedge pclk);
		alarm_event <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : fire

	// Hang guard, far above the expected run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		logic [15:0] c;
		int k;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		cmd_valid <= 1'b1;
		acc(1'b0, AHS_IDX_CTRL, 32'h0000_0182, 1'b0);
		acc(1'b0, 16'h2a60, 32'h0, 1'b1);
		acc(1'b1, AHS_IDX_ALM_WIDE, 32'h0, 1'b1);
		acc(1'b0, AHS_IDX_CLR_KEY, 32'h0, 1'b1);
		for (int i = 0; i < 17; i++) begin
			k = i % 8;
			c = 16'h0100 + 16'(i);
			acc(1'b1, AHS_IDX_CTRL, ctl_tab[k], 1'b0);
			fire(c, m_tab[k]);
			chk("alarm_out", {31'h0, alarm_out}, 32'h0);
			chk("interlock", {31'h0, brake_interlock_out_alt}, 32'h0);
			chk("decel", {31'h0, decel_cmd_out}, {31'h0, k == 7});
			speed_low <= 1'b1;
			repeat (3) @(posedge pclk);
			speed_low <= 1'b0;
			chk("action", {30'h0, brake_action_out}, {30'h0, a_tab[k]});
			chk("accept", {31'h0, cmd_accept_out}, 32'h0);
			acc(1'b0, AHS_IDX_ALM_WIDE, {16'h0, c}, 1'b0);
			acc(1'b0, AHS_IDX_ALM_NAR, {16'h0, c}, 1'b0);
			acc(1'b1, AHS_IDX_RST_KEY, 32'h0000_1ea4, 1'b0);
			chk("held", {31'h0, base_off_out}, 32'h1);
			acc(1'b1, AHS_IDX_RST_KEY, 32'h0000_1ea5, 1'b0);
			repeat (2) @(posedge pclk);
			chk("healthy", {31'h0, alarm_out}, 32'h1);
			chk("accept", {31'h0, cmd_accept_out}, 32'h1);
		end
		acc(1'b0, AHS_IDX_ALM_WIDE, 32'h0, 1'b0);
		sub(AHS_IDX_HIST0, 8'h01, 32'h0110_feef);
		sub(AHS_IDX_HIST0, 8'h02, 32'h0000_0110);
		sub(AHS_IDX_HIST0, 8'h03, 32'h0);
		sub(AHS_IDX_HIST0, 8'h04, 32'h0110_0110);
		sub(AHS_IDX_HIST0, 8'h05, 32'h0110_0001);
		sub(AHS_IDX_HIST0, 8'h06, 32'h0110_0002);
		sub(AHS_IDX_HIST0, 8'h07, 32'h0110_0003);
		sub(AHS_IDX_HIST15, 8'h00, 32'h7);
		sub(AHS_IDX_HIST15, 8'h01, 32'h0101_fefe);
		acc(1'b1, AHS_IDX_CLR_KEY, 32'h0000_1ea4, 1'b0);
		sub(AHS_IDX_HIST0, 8'h01, 32'h0110_feef);
		acc(1'b1, AHS_IDX_CLR_KEY, 32'h0000_1ea5, 1'b0);
		sub(AHS_IDX_HIST0, 8'h01, 32'h0);
		{pt_fault_pin, pt_num_pin, pt_elem_pin} <= {1'b1, 16'h0031, 16'h0005};
		repeat (6) @(posedge pclk);
		pt_fault_pin <= 1'b0;
		sub(AHS_IDX_PT_FAULT, 8'h00, 32'h2);
		sub(AHS_IDX_PT_FAULT, 8'h01, 32'h31);
		sub(AHS_IDX_PT_FAULT, 8'h02, 32'h5);
		for (int j = 0; j < 3; j++) begin
			pf_param_pin <= 16'h0200 + 16'(j);
			repeat (4) @(posedge pclk);
			pf_push_pin <= 1'b1;
			repeat (5) @(posedge pclk);
			pf_push_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		chk("pf_alarm", {31'h0, parameter_fault_alarm}, 32'h1);
		acc(1'b0, AHS_IDX_PF_COUNT, 32'h3, 1'b0);
		sub(AHS_IDX_PF_LIST, 8'h00, 32'hfe);
		for (int j = 0; j < 3; j++) sub(AHS_IDX_PF_LIST, 8'(j + 1), 32'h0200 + j);
		wrap_up();
	end
endmodule : ahs_top_tb_top
